// file: include/cmd_decode_pkg.sv
package cmd_decode_pkg;

  // one-hot command codes after chip-select masking
  typedef enum logic [7:0] {
    CMD_NOP = 8'h01,
    CMD_MRS = 8'h02,
    CMD_REF = 8'h04,
    CMD_PRE = 8'h08,
    CMD_ACT = 8'h10,
    CMD_WR  = 8'h20,
    CMD_RD  = 8'h40,
    CMD_ZQ  = 8'h80
  } cmd_t;

  // {ras_n, cas_n, we_n} patterns with chip select low
  localparam logic [2:0] PAT_MRS = 3'h0;
  localparam logic [2:0] PAT_REF = 3'h1;
  localparam logic [2:0] PAT_PRE = 3'h2;
  localparam logic [2:0] PAT_ACT = 3'h3;
  localparam logic [2:0] PAT_WR  = 3'h4;
  localparam logic [2:0] PAT_RD  = 3'h5;
  localparam logic [2:0] PAT_ZQ  = 3'h6;

  localparam int BANKS    = 8;
  localparam int BA_W     = 3;
  localparam int ADDR_W   = 15;
  localparam int COL_W    = 10;
  localparam int MR_COUNT = 4;
  localparam int MR_SEL_W = 2;
  localparam int DQ_W     = 8;

  // address bit positions with a second meaning
  localparam int AP_BIT   = 10;
  localparam int CHOP_BIT = 12;

  // mode register field positions
  localparam int MR0_BL_LSB    = 0;
  localparam int MR1_TDQS_BIT  = 11;
  localparam int MR1_RTT_B0    = 2;
  localparam int MR1_RTT_B1    = 6;
  localparam int MR1_RTT_B2    = 9;
  localparam int MR2_RTTWR_LSB = 9;
  localparam int MR_IDX_MR0    = 0;
  localparam int MR_IDX_MR1    = 1;
  localparam int MR_IDX_MR2    = 2;

  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF    = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;

  // values after reset
  localparam logic [ADDR_W-1:0] MR_RST   = 15'h0000;
  localparam logic [ADDR_W-1:0] ROW_RST  = 15'h0000;
  localparam logic [BANKS-1:0]  OPEN_RST = 8'h00;

endpackage : cmd_decode_pkg

// file: src/write_beat_mask.sv
`timescale 1ns/1ps
module write_beat_mask #(
  parameter int DATA_W = 8
) (
  input  wire logic              ref_clk,
  input  wire logic              srst,
  input  wire logic              reset_n,
  input  wire logic              beat_valid,
  input  wire logic [DATA_W-1:0] beat_data,
  input  wire logic              dm,
  input  wire logic              dm_mode,
  output logic                   arr_we_q,
  output logic [DATA_W-1:0]      arr_data_q,
  output logic                   beat_masked_q
);

  logic              arr_we_d;
  logic [DATA_W-1:0] arr_data_d;
  logic              beat_masked_d;
  logic              masked;

  if (DATA_W < 1) begin : g_chk
    $error("write_beat_mask: DATA_W must be at least 1");
  end

  ////////////////////////////////////////////////////////////////////////////
  // one beat per rising clock edge; the mask only counts while the shared ball is dm
  always_comb begin
    masked        = beat_valid && dm && dm_mode;
    arr_we_d      = beat_valid && !masked;
    arr_data_d    = beat_valid ? beat_data : arr_data_q;
    beat_masked_d = masked;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      arr_we_q      <= 1'b0;
      arr_data_q    <= '0;
      beat_masked_q <= 1'b0;
    end else if (srst) begin
      arr_we_q      <= 1'b0;
      arr_data_q    <= '0;
      beat_masked_q <= 1'b0;
    end else begin
      arr_we_q      <= arr_we_d;
      arr_data_q    <= arr_data_d;
      beat_masked_q <= beat_masked_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_masked_beat;
    @(posedge ref_clk) disable iff (srst || !reset_n)
      (beat_valid && dm && dm_mode) |=> (!arr_we_q && beat_masked_q);
  endproperty
  a_masked_beat: assert property (p_masked_beat) else $error("masked beat written");

  property p_beat_written;
    @(posedge ref_clk) disable iff (srst || !reset_n)
      (beat_valid && !(dm && dm_mode)) |=> (arr_we_q && arr_data_q == $past(beat_data));
  endproperty
  a_beat_written: assert property (p_beat_written) else $error("beat not written");

  c_masked_beat: cover property (@(posedge ref_clk) beat_valid && dm && dm_mode);

endmodule : write_beat_mask

// file: src/ddr3_cmd_addr_pin_decode.sv
`timescale 1ns/1ps
// Operation
// - inputs captured on rising clock edge
// - chip select high masks the command
// - command from cs, ras, cas, we
// - captured termination input enables termination
// - termination on data, strobes, mask; tdqs_n optional
// - termination ignored if disabled or self refresh
// - masked write beat not written
// - mask sampled per data beat, rising clock edge only
// - mr1 a11 selects mask or tdqs
// - bank inputs select target bank
// - bank inputs select mode register
// - address bits loaded as mode op-code
// - a10 on read/write requests auto-precharge
// - a10 on precharge closes all banks
// - a12 low chops burst, high full
// - a12 counts only with on-the-fly mode
// - reset low resets without a clock
// - data need not survive a reset
module ddr3_cmd_addr_pin_decode #(
  parameter int BANK_N = cmd_decode_pkg::BANKS,
  parameter int ROW_W  = cmd_decode_pkg::ADDR_W,
  parameter int DATA_W = cmd_decode_pkg::DQ_W
) (
  input  wire logic                            ref_clk,
  input  wire logic                            srst,
  input  wire logic                            reset_n,
  input  wire logic                            cs_n,
  input  wire logic                            ras_n,
  input  wire logic                            cas_n,
  input  wire logic                            we_n,
  input  wire logic [cmd_decode_pkg::BA_W-1:0] ba,
  input  wire logic [ROW_W-1:0]                addr,
  input  wire logic                            odt,
  input  wire logic                            self_refresh,
  input  wire logic                            beat_valid,
  input  wire logic [DATA_W-1:0]               beat_data,
  input  wire logic                            dm,
  output logic                                 cmd_valid_q,
  output cmd_decode_pkg::cmd_t                 cmd_q,
  output logic [cmd_decode_pkg::BA_W-1:0]      bank_q,
  output logic [ROW_W-1:0]                     row_addr_q,
  output logic [cmd_decode_pkg::COL_W-1:0]     col_addr_q,
  output logic                                 auto_pre_q,
  output logic                                 pre_all_q,
  output logic                                 burst_chop_q,
  output logic                                 mr_wr_q,
  output logic [cmd_decode_pkg::MR_SEL_W-1:0]  mr_sel_q,
  output logic [BANK_N-1:0]                    bank_open,
  output logic                                 odt_term_q,
  output logic                                 tdqs_n_term_q,
  output logic                                 dm_mode,
  output logic                                 arr_we_q,
  output logic [DATA_W-1:0]                    arr_data_q,
  output logic                                 beat_masked_q
);

  if (BANK_N != cmd_decode_pkg::BANKS || ROW_W != cmd_decode_pkg::ADDR_W) begin : g_chk
    $error("ddr3_cmd_addr_pin_decode: eight banks and 15 address bits only");
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic cmd_decode_pkg::cmd_t decode_cmd(
    input logic s_n,
    input logic r_n,
    input logic c_n,
    input logic w_n
  );
    cmd_decode_pkg::cmd_t c;
    c = cmd_decode_pkg::CMD_NOP;
    if (!s_n) begin
      case ({r_n, c_n, w_n})
        cmd_decode_pkg::PAT_MRS: c = cmd_decode_pkg::CMD_MRS;
        cmd_decode_pkg::PAT_REF: c = cmd_decode_pkg::CMD_REF;
        cmd_decode_pkg::PAT_PRE: c = cmd_decode_pkg::CMD_PRE;
        cmd_decode_pkg::PAT_ACT: c = cmd_decode_pkg::CMD_ACT;
        cmd_decode_pkg::PAT_WR:  c = cmd_decode_pkg::CMD_WR;
        cmd_decode_pkg::PAT_RD:  c = cmd_decode_pkg::CMD_RD;
        cmd_decode_pkg::PAT_ZQ:  c = cmd_decode_pkg::CMD_ZQ;
        default:                 c = cmd_decode_pkg::CMD_NOP;
      endcase
    end
    return c;
  endfunction : decode_cmd

  // termination is off only when both the nominal and the write value are zero
  function automatic logic rtt_enabled(
    input logic [ROW_W-1:0] m1,
    input logic [ROW_W-1:0] m2
  );
    logic nom;
    logic wr;
    nom = m1[cmd_decode_pkg::MR1_RTT_B0] | m1[cmd_decode_pkg::MR1_RTT_B1]
        | m1[cmd_decode_pkg::MR1_RTT_B2];
    wr  = |m2[cmd_decode_pkg::MR2_RTTWR_LSB +: 2];
    return nom | wr;
  endfunction : rtt_enabled

  ////////////////////////////////////////////////////////////////////////////
  // state

  cmd_decode_pkg::cmd_t                   cmd_c;
  logic                                   cmd_valid_d;
  cmd_decode_pkg::cmd_t                   cmd_d;
  logic [cmd_decode_pkg::BA_W-1:0]        bank_d;
  logic [ROW_W-1:0]                       row_addr_d;
  logic [cmd_decode_pkg::COL_W-1:0]       col_addr_d;
  logic                                   auto_pre_d;
  logic                                   pre_all_d;
  logic                                   burst_chop_d;
  logic                                   mr_wr_d;
  logic [cmd_decode_pkg::MR_SEL_W-1:0]    mr_sel_d;
  logic [BANK_N-1:0]                      open_q;
  logic [BANK_N-1:0]                      open_d;
  logic [BANK_N-1:0][ROW_W-1:0]           row_q;
  logic [BANK_N-1:0][ROW_W-1:0]           row_d;
  logic [cmd_decode_pkg::MR_COUNT-1:0][ROW_W-1:0] mr_q;
  logic [cmd_decode_pkg::MR_COUNT-1:0][ROW_W-1:0] mr_d;
  logic                                   odt_term_d;
  logic                                   tdqs_n_term_d;
  logic                                   is_rw;
  logic [1:0]                             bl_field;

  assign bank_open = open_q;
  assign dm_mode   = !mr_q[cmd_decode_pkg::MR_IDX_MR1][cmd_decode_pkg::MR1_TDQS_BIT];
  assign bl_field  = mr_q[cmd_decode_pkg::MR_IDX_MR0][cmd_decode_pkg::MR0_BL_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////////
  // command, bank and mode-register next state

  always_comb begin
    cmd_c         = decode_cmd(cs_n, ras_n, cas_n, we_n);
    is_rw         = (cmd_c == cmd_decode_pkg::CMD_RD) || (cmd_c == cmd_decode_pkg::CMD_WR);
    cmd_valid_d   = !cs_n;
    cmd_d         = cmd_c;
    bank_d        = ba;
    row_addr_d    = addr;
    col_addr_d    = addr[cmd_decode_pkg::COL_W-1:0];
    auto_pre_d    = is_rw && addr[cmd_decode_pkg::AP_BIT];
    pre_all_d     = (cmd_c == cmd_decode_pkg::CMD_PRE) && addr[cmd_decode_pkg::AP_BIT];
    burst_chop_d  = 1'b0;
    mr_wr_d       = 1'b0;
    mr_sel_d      = ba[cmd_decode_pkg::MR_SEL_W-1:0];
    open_d        = open_q;
    row_d         = row_q;
    mr_d          = mr_q;
    if (is_rw) begin
      // a12 only overrides the length when on-the-fly is programmed
      if (bl_field == cmd_decode_pkg::BL_OTF) begin
        burst_chop_d = !addr[cmd_decode_pkg::CHOP_BIT];
      end else begin
        burst_chop_d = (bl_field == cmd_decode_pkg::BL_FIXED4);
      end
    end
    case (cmd_c)
      cmd_decode_pkg::CMD_ACT: begin
        open_d[ba] = 1'b1;
        row_d[ba]  = addr;
      end
      cmd_decode_pkg::CMD_PRE: begin
        if (addr[cmd_decode_pkg::AP_BIT]) begin
          open_d = '0;
        end else begin
          open_d[ba] = 1'b0;
        end
      end
      cmd_decode_pkg::CMD_RD, cmd_decode_pkg::CMD_WR: begin
        // with a10 set the bank is marked closed at the command; burst timing is outside
        if (addr[cmd_decode_pkg::AP_BIT]) begin
          open_d[ba] = 1'b0;
        end
      end
      cmd_decode_pkg::CMD_MRS: begin
        // ba2 set addresses no register, so no mode register is written
        if (!ba[cmd_decode_pkg::BA_W-1]) begin
          mr_wr_d        = 1'b1;
          mr_d[mr_sel_d] = addr;
        end
      end
      default: begin
        open_d = open_q;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // termination gating

  always_comb begin
    odt_term_d    = odt && !self_refresh
                    && rtt_enabled(mr_q[cmd_decode_pkg::MR_IDX_MR1],
                                   mr_q[cmd_decode_pkg::MR_IDX_MR2]);
    tdqs_n_term_d = odt_term_d && !dm_mode;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers; the pin reset clears everything without a clock

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_valid_q   <= 1'b0;
      cmd_q         <= cmd_decode_pkg::CMD_NOP;
      bank_q        <= '0;
      row_addr_q    <= '0;
      col_addr_q    <= '0;
      auto_pre_q    <= 1'b0;
      pre_all_q     <= 1'b0;
      burst_chop_q  <= 1'b0;
      mr_wr_q       <= 1'b0;
      mr_sel_q      <= '0;
      open_q        <= cmd_decode_pkg::OPEN_RST;
      row_q         <= {BANK_N{cmd_decode_pkg::ROW_RST}};
      mr_q          <= {cmd_decode_pkg::MR_COUNT{cmd_decode_pkg::MR_RST}};
      odt_term_q    <= 1'b0;
      tdqs_n_term_q <= 1'b0;
    end else if (srst) begin
      cmd_valid_q   <= 1'b0;
      cmd_q         <= cmd_decode_pkg::CMD_NOP;
      bank_q        <= '0;
      row_addr_q    <= '0;
      col_addr_q    <= '0;
      auto_pre_q    <= 1'b0;
      pre_all_q     <= 1'b0;
      burst_chop_q  <= 1'b0;
      mr_wr_q       <= 1'b0;
      mr_sel_q      <= '0;
      open_q        <= cmd_decode_pkg::OPEN_RST;
      row_q         <= {BANK_N{cmd_decode_pkg::ROW_RST}};
      mr_q          <= {cmd_decode_pkg::MR_COUNT{cmd_decode_pkg::MR_RST}};
      odt_term_q    <= 1'b0;
      tdqs_n_term_q <= 1'b0;
    end else begin
      cmd_valid_q   <= cmd_valid_d;
      cmd_q         <= cmd_d;
      bank_q        <= bank_d;
      row_addr_q    <= row_addr_d;
      col_addr_q    <= col_addr_d;
      auto_pre_q    <= auto_pre_d;
      pre_all_q     <= pre_all_d;
      burst_chop_q  <= burst_chop_d;
      mr_wr_q       <= mr_wr_d;
      mr_sel_q      <= mr_sel_d;
      open_q        <= open_d;
      row_q         <= row_d;
      mr_q          <= mr_d;
      odt_term_q    <= odt_term_d;
      tdqs_n_term_q <= tdqs_n_term_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write data path

  write_beat_mask #(
    .DATA_W (DATA_W)
  ) u_mask (
    .ref_clk       (ref_clk),
    .srst          (srst),
    .reset_n       (reset_n),
    .beat_valid    (beat_valid),
    .beat_data     (beat_data),
    .dm            (dm),
    .dm_mode       (dm_mode),
    .arr_we_q      (arr_we_q),
    .arr_data_q    (arr_data_q),
    .beat_masked_q (beat_masked_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_cs_mask;
    @(posedge ref_clk) disable iff (srst || !reset_n)
      cs_n |=> (!cmd_valid_q && cmd_q == cmd_decode_pkg::CMD_NOP && !mr_wr_q);
  endproperty
  a_cs_mask: assert property (p_cs_mask) else $error("masked command acted on");

  property p_masked_hold;
    @(posedge ref_clk) disable iff (srst || !reset_n)
      cs_n |=> ($stable(open_q) && $stable(mr_q) && $stable(row_q));
  endproperty
  a_masked_hold: assert property (p_masked_hold) else $error("masked cycle changed state");

  property p_act_open;
    @(posedge ref_clk) disable iff (srst || !reset_n)
      (cmd_c == cmd_decode_pkg::CMD_ACT) |=>
        (open_q[bank_q] && row_q[bank_q] == $past(addr) && bank_q == $past(ba));
  endproperty
  a_act_open: assert property (p_act_open) else $error("activate did not open row");

  property p_pre_all;
    @(posedge ref_clk) disable iff (srst || !reset_n)
      (cmd_c == cmd_decode_pkg::CMD_PRE && addr[cmd_decode_pkg::AP_BIT])
        |=> (open_q == '0 && pre_all_q);
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("precharge all left a bank open");

  property p_pre_one;
    @(posedge ref_clk) disable iff (srst || !reset_n)
      (cmd_c == cmd_decode_pkg::CMD_PRE && !addr[cmd_decode_pkg::AP_BIT])
        |=> (!open_q[bank_q] && !pre_all_q
             && (open_q | (BANK_N'(1) << bank_q)) == ($past(open_q) | (BANK_N'(1) << bank_q)));
  endproperty
  a_pre_one: assert property (p_pre_one) else $error("single precharge wrong");

  property p_mrs_load;
    @(posedge ref_clk) disable iff (srst || !reset_n)
      (cmd_c == cmd_decode_pkg::CMD_MRS && !ba[cmd_decode_pkg::BA_W-1])
        |=> (mr_wr_q && mr_q[mr_sel_q] == $past(addr));
  endproperty
  a_mrs_load: assert property (p_mrs_load) else $error("mode register not loaded");

  property p_auto_pre;
    @(posedge ref_clk) disable iff (srst || !reset_n)
      is_rw |=> (auto_pre_q == $past(addr[cmd_decode_pkg::AP_BIT])
                 && col_addr_q == $past(addr[cmd_decode_pkg::COL_W-1:0]));
  endproperty
  a_auto_pre: assert property (p_auto_pre) else $error("auto-precharge flag wrong");

  property p_chop;
    @(posedge ref_clk) disable iff (srst || !reset_n)
      (is_rw && bl_field == cmd_decode_pkg::BL_OTF)
        |=> (burst_chop_q == !$past(addr[cmd_decode_pkg::CHOP_BIT]));
  endproperty
  a_chop: assert property (p_chop) else $error("burst chop wrong");

  property p_chop_fixed;
    @(posedge ref_clk) disable iff (srst || !reset_n)
      (is_rw && bl_field == cmd_decode_pkg::BL_FIXED8) |=> !burst_chop_q;
  endproperty
  a_chop_fixed: assert property (p_chop_fixed) else $error("a12 used without otf");

  property p_odt_off;
    @(posedge ref_clk) disable iff (srst || !reset_n)
      (self_refresh || !odt) |=> (!odt_term_q ##1 1'b1);
  endproperty
  a_odt_off: assert property (p_odt_off) else $error("termination during self refresh");

  property p_tdqs_term;
    @(posedge ref_clk) disable iff (srst || !reset_n)
      tdqs_n_term_q |-> (odt_term_q && !$past(dm_mode));
  endproperty
  a_tdqs_term: assert property (p_tdqs_term) else $error("tdqs_n terminated in mask mode");

  property p_pin_reset;
    @(posedge ref_clk) !reset_n |-> (open_q == '0 && !cmd_valid_q && !odt_term_q);
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("state kept through reset");

  c_act:  cover property (@(posedge ref_clk) cmd_c == cmd_decode_pkg::CMD_ACT);
  c_mrs:  cover property (@(posedge ref_clk) cmd_c == cmd_decode_pkg::CMD_MRS);
  c_odt:  cover property (@(posedge ref_clk) odt_term_q && tdqs_n_term_q);
  c_chop: cover property (@(posedge ref_clk) burst_chop_q && cmd_valid_q);

endmodule : ddr3_cmd_addr_pin_decode

// file: tb/ctrl_model.sv
`timescale 1ns/1ps
module ctrl_model (
  input  wire logic ref_clk,
  output logic      reset_n,
  output logic      cs_n,
  output logic      ras_n,
  output logic      cas_n,
  output logic      we_n,
  output logic [2:0]  ba,
  output logic [14:0] addr,
  output logic      odt,
  output logic      self_refresh,
  output logic      beat_valid,
  output logic [7:0]  beat_data,
  output logic      dm
);
  initial begin
    reset_n = 1'h1;
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
    ba = 3'h0;
    addr = 15'h0000;
    {odt, self_refresh, beat_valid, dm} = 4'h0;
    beat_data = 8'h00;
  end
  //////////////////////////////////////////////////////////////////
  // entered at a falling edge; returns one falling edge later
  task cmd(input logic c, input logic [2:0] p, input logic [2:0] b, input logic [14:0] a);
    cs_n = c;
    {ras_n, cas_n, we_n} = p;
    ba = b;
    addr = a;
    beat_valid = 1'h0;
    @(negedge ref_clk);
  endtask : cmd
  // command lines not in use show the inverse, never a stale copy
  task beat(input logic [7:0] d, input logic m);
    cs_n = 1'h1;
    {ras_n, cas_n, we_n} = ~{ras_n, cas_n, we_n};
    ba = ~ba;
    addr = ~addr;
    beat_valid = 1'h1;
    beat_data = d;
    dm = m;
    @(negedge ref_clk);
  endtask : beat
  task set_term(input logic o, input logic s);
    odt = o;
    self_refresh = s;
  endtask : set_term
  // drop reset between edges so only an asynchronous path can clear
  task hit_reset;
    #1 reset_n = 1'h0;
    #1;
  endtask : hit_reset
  task rel;
    @(negedge ref_clk);
    reset_n = 1'h1;
  endtask : rel
endmodule : ctrl_model

// file: tb/ddr3_cmd_addr_pin_decode_tb.sv
`timescale 1ns/1ps
module ddr3_cmd_addr_pin_decode_tb;
  logic ref_clk, srst;
  logic reset_n, cs_n, ras_n, cas_n, we_n, odt, self_refresh, beat_valid, dm;
  logic [2:0] ba, bank_q;
  logic [14:0] addr, row_addr_q;
  logic [7:0] beat_data, arr_data_q, bank_open;
  logic [9:0] col_addr_q;
  logic [1:0] mr_sel_q;
  logic cmd_valid_q, auto_pre_q, pre_all_q, burst_chop_q, mr_wr_q, odt_term_q;
  logic tdqs_n_term_q, dm_mode, arr_we_q, beat_masked_q;
  cmd_decode_pkg::cmd_t cmd_q;
  int failures, compares;
  ctrl_model m (.ref_clk, .reset_n, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .odt,
    .self_refresh, .beat_valid, .beat_data, .dm);
  ddr3_cmd_addr_pin_decode uut (.ref_clk, .srst, .reset_n, .cs_n, .ras_n, .cas_n, .we_n,
    .ba, .addr, .odt, .self_refresh, .beat_valid, .beat_data, .dm, .cmd_valid_q, .cmd_q,
    .bank_q, .row_addr_q, .col_addr_q, .auto_pre_q, .pre_all_q, .burst_chop_q, .mr_wr_q,
    .mr_sel_q, .bank_open, .odt_term_q, .tdqs_n_term_q, .dm_mode, .arr_we_q, .arr_data_q,
    .beat_masked_q);
  //////////////////////////////////////////////////////////////////
  task chk(input logic [14:0] got, input logic [14:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : chk
  task chkc(input cmd_decode_pkg::cmd_t got, input cmd_decode_pkg::cmd_t exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t command code", $time);
    end
  endtask : chkc
  task end_sim;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  //////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // the sequence takes about 38 cycles; far more is a hang
  initial begin
    #20000;
    failures++;
    end_sim();
  end
  initial begin
    srst = 1'h1;
    // count rising edges: the clock's first assignment is itself a falling edge
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    srst = 1'h0;
    chkc(cmd_q, cmd_decode_pkg::CMD_NOP);
    chk(dm_mode, 1'h1, "reset mode");
    m.cmd(1'h0, cmd_decode_pkg::PAT_ACT, 3'h2, 15'h5A5A);
    chkc(cmd_q, cmd_decode_pkg::CMD_ACT);
    chk(bank_q, 3'h2, "bank");
    chk(row_addr_q, 15'h5A5A, "row");
    m.cmd(1'h0, cmd_decode_pkg::PAT_ACT, 3'h7, 15'h7FFF);
    chk(bank_open, 8'h84, "open map");
    chk(row_addr_q, 15'h7FFF, "row max");
    m.cmd(1'h1, cmd_decode_pkg::PAT_PRE, 3'h7, 15'h0400);
    chk(cmd_valid_q, 1'h0, "masked valid");
    chkc(cmd_q, cmd_decode_pkg::CMD_NOP);
    chk(bank_open, 8'h84, "masked state");
    m.cmd(1'h0, cmd_decode_pkg::PAT_RD, 3'h7, 15'h07FF);
    chkc(cmd_q, cmd_decode_pkg::CMD_RD);
    chk(col_addr_q, 10'h3FF, "column");
    chk(auto_pre_q, 1'h1, "auto pre");
    chk(burst_chop_q, 1'h0, "fixed burst");
    chk(bank_open, 8'h04, "auto close");
    m.cmd(1'h0, cmd_decode_pkg::PAT_REF, 3'h0, 15'h0000);
    chkc(cmd_q, cmd_decode_pkg::CMD_REF);
    m.cmd(1'h0, cmd_decode_pkg::PAT_ZQ, 3'h0, 15'h0400);
    chkc(cmd_q, cmd_decode_pkg::CMD_ZQ);
    chk(pre_all_q, 1'h0, "zq not precharge");
    $display("test commands done");
    m.cmd(1'h0, cmd_decode_pkg::PAT_MRS, 3'h0, 15'h0001);
    chk(mr_wr_q, 1'h1, "mrs");
    chk(mr_sel_q, 2'h0, "mrs sel");
    m.cmd(1'h0, cmd_decode_pkg::PAT_WR, 3'h2, 15'h0000);
    chkc(cmd_q, cmd_decode_pkg::CMD_WR);
    chk(burst_chop_q, 1'h1, "chop");
    chk(auto_pre_q, 1'h0, "no auto pre");
    chk(bank_open, 8'h04, "bank stays");
    m.cmd(1'h0, cmd_decode_pkg::PAT_WR, 3'h2, 15'h1000);
    chk(burst_chop_q, 1'h0, "full burst");
    m.cmd(1'h0, cmd_decode_pkg::PAT_MRS, 3'h4, 15'h7FFF);
    chk(mr_wr_q, 1'h0, "bad mrs");
    chk(cmd_valid_q, 1'h1, "bad mrs valid");
    m.cmd(1'h0, cmd_decode_pkg::PAT_RD, 3'h2, 15'h0000);
    chk(burst_chop_q, 1'h1, "mode kept");
    m.cmd(1'h0, cmd_decode_pkg::PAT_MRS, 3'h0, 15'h0002);
    m.cmd(1'h0, cmd_decode_pkg::PAT_RD, 3'h2, 15'h1000);
    chk(burst_chop_q, 1'h1, "fixed chop");
    m.cmd(1'h0, cmd_decode_pkg::PAT_ACT, 3'h1, 15'h0000);
    m.cmd(1'h0, cmd_decode_pkg::PAT_ACT, 3'h5, 15'h0000);
    m.cmd(1'h0, cmd_decode_pkg::PAT_PRE, 3'h2, 15'h0000);
    chk(bank_open, 8'h22, "pre one");
    chk(pre_all_q, 1'h0, "pre one flag");
    m.cmd(1'h0, cmd_decode_pkg::PAT_PRE, 3'h3, 15'h0400);
    chk(bank_open, 8'h00, "pre all");
    chk(pre_all_q, 1'h1, "pre all flag");
    $display("test mode and banks done");
    m.set_term(1'h1, 1'h0);
    m.cmd(1'h1, 3'h7, 3'h0, 15'h0000);
    chk(odt_term_q, 1'h0, "term off in mr");
    m.cmd(1'h0, cmd_decode_pkg::PAT_MRS, 3'h1, 15'h0804);
    chk(dm_mode, 1'h0, "tdqs mode");
    chk(mr_sel_q, 2'h1, "mr1 sel");
    m.cmd(1'h1, 3'h7, 3'h0, 15'h0000);
    chk(odt_term_q, 1'h1, "term on");
    chk(tdqs_n_term_q, 1'h1, "tdqs term");
    m.set_term(1'h1, 1'h1);
    m.cmd(1'h1, 3'h7, 3'h0, 15'h0000);
    chk(odt_term_q, 1'h0, "self refresh");
    m.beat(8'h3C, 1'h1);
    chk(arr_we_q, 1'h1, "dm ignored");
    chk(arr_data_q, 8'h3C, "tdqs data");
    m.set_term(1'h1, 1'h0);
    m.cmd(1'h0, cmd_decode_pkg::PAT_MRS, 3'h1, 15'h0000);
    m.cmd(1'h0, cmd_decode_pkg::PAT_MRS, 3'h2, 15'h0200);
    chk(mr_sel_q, 2'h2, "mr2 sel");
    m.cmd(1'h1, 3'h7, 3'h0, 15'h0000);
    chk(odt_term_q, 1'h1, "write term");
    chk(tdqs_n_term_q, 1'h0, "no tdqs term");
    chk(dm_mode, 1'h1, "mask mode");
    $display("test termination done");
    m.beat(8'hA5, 1'h0);
    chk(arr_we_q, 1'h1, "beat written");
    chk(arr_data_q, 8'hA5, "beat data");
    m.beat(8'h5A, 1'h1);
    chk(arr_we_q, 1'h0, "masked write");
    chk(beat_masked_q, 1'h1, "masked flag");
    m.beat(8'hFF, 1'h0);
    chk(arr_data_q, 8'hFF, "next beat");
    chk(beat_masked_q, 1'h0, "unmasked flag");
    $display("test beats done");
    m.cmd(1'h0, cmd_decode_pkg::PAT_MRS, 3'h1, 15'h0800);
    m.cmd(1'h0, cmd_decode_pkg::PAT_ACT, 3'h6, 15'h0000);
    m.hit_reset();
    chk(bank_open, 8'h00, "async clear");
    chk(dm_mode, 1'h1, "mode cleared");
    m.rel();
    m.cmd(1'h1, 3'h7, 3'h0, 15'h0000);
    chk(odt_term_q, 1'h0, "mr lost");
    $display("test reset done");
    end_sim();
  end
endmodule : ddr3_cmd_addr_pin_decode_tb
